// >>> src/rcc_pkg.sv
// Notes on behaviour
// - reference runs only while the software enable bit is set
// - ready bit sets only after reference and amplifiers have settled
// - two independent gain stages, each selectable for 1x, 2x or 4x
// - two-bit field enables and sets converter-path gain stage
// - second two-bit field sets dac/comparator gain stage independently
// - rising enable bit 1 lets rising comparator edges set the flag
// - falling enable bit 0 lets falling comparator edges set the flag
// - inverting select: 0-3 inputs, 4-5 open, 6 buffer two, 7 ground
// - spare bits of select and edge registers ignore writes, read zero
package rcc_pkg;
    // ***********************************************************
    // register byte offsets
    // ***********************************************************
    localparam logic [7:0] REF_CTRL_OFS = 8'h00;
    localparam logic [7:0] EDGE_CTRL_OFS = 8'h04;
    localparam logic [7:0] INV_CHAN_OFS = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h0C;
    localparam logic [7:0] IRQ_EN_OFS = 8'h10;
    localparam logic [7:0] IRQ_CLR_OFS = 8'h14;
    localparam logic [7:0] CMP_STAT_OFS = 8'h18;
    // ***********************************************************
    // reference control fields
    // ***********************************************************
    localparam int REF_EN_BIT = 7;
    localparam int REF_RDY_BIT = 6;
    localparam int DAC_GAIN_LSB = 2;
    localparam int ADC_GAIN_LSB = 0;
    localparam int RISE_EN_BIT = 1;
    localparam int FALL_EN_BIT = 0;
    localparam logic [1:0] GAIN_OFF = 2'h0;
    localparam logic [1:0] GAIN_X1 = 2'h1;
    localparam logic [1:0] GAIN_X2 = 2'h2;
    localparam logic [1:0] GAIN_X4 = 2'h3;
    // ***********************************************************
    // reset values and settling time
    // ***********************************************************
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int CLK_MHZ = 100;
    localparam int SETTLE_US = 25;
    localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
    // ***********************************************************
    // inverting input routes
    // ***********************************************************
    typedef enum logic [2:0] {
        INV_INPUT_ZERO = 3'b000,
        INV_INPUT_ONE = 3'b001,
        INV_INPUT_TWO = 3'b010,
        INV_INPUT_THREE = 3'b011,
        INV_OPEN_A = 3'b100,
        INV_OPEN_B = 3'b101,
        INV_REF_BUFFER_TWO = 3'b110,
        INV_GROUND = 3'b111
    } rcc_inv_sel_type;
endpackage

// >>> src/rcc_sync.sv
// two-flop synchroniser for the asynchronous comparator output
module rcc_sync (
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic din, // asynchronous level
    output logic dout // synchronised level
);
    logic meta_reg;
    // first flop is read only by the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end
endmodule // rcc_sync

// >>> src/rcc_gain_dec.sv
// decodes one two-bit gain field into stage enable and one-hot gain
module rcc_gain_dec (
    input wire logic [1:0] code, // gain field
    output logic enable, // stage powered
    output logic [2:0] gain_onehot // bit0 1x, bit1 2x, bit2 4x
);
    // code 00 leaves the stage off and no gain selected
    assign enable = (code != rcc_pkg::GAIN_OFF);
    assign gain_onehot[0] = (code == rcc_pkg::GAIN_X1);
    assign gain_onehot[1] = (code == rcc_pkg::GAIN_X2);
    assign gain_onehot[2] = (code == rcc_pkg::GAIN_X4);
endmodule // rcc_gain_dec

// >>> src/rcc_top.sv
// reference and comparator control with an axi4-lite register slave
module rcc_top #(
    parameter int SETTLE_CYCLES = rcc_pkg::SETTLE_CYCLES // settle count
) (
    input wire logic aclk, // 100 MHz clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read valid
    input wire logic s_axi_rready, // read ready
    input wire logic cmp_output, // raw comparator output, async
    output logic fixed_reference_en, // reference powered
    output logic adc_stage_en, // converter gain stage on
    output logic [2:0] adc_gain_onehot, // converter gain 1x/2x/4x
    output logic dac_stage_en, // dac/comparator stage on
    output logic [2:0] dac_gain_onehot, // dac/comparator gain 1x/2x/4x
    output logic [3:0] inv_input_route, // one-hot inputs zero..three
    output logic inv_ref_buffer_two, // route buffer two
    output logic inv_ground, // route ground
    output logic irq // level interrupt
);
    // ***********************************************************
    // registers
    // ***********************************************************
    // counter wide enough to hold the settle count itself
    localparam int CW = $clog2(SETTLE_CYCLES + 1);
    logic ref_en_reg;
    logic [1:0] adc_ref_gain_sel_reg;
    logic [1:0] dac_cmp_ref_gain_sel_reg;
    logic ready_reg;
    logic [CW-1:0] settle_cnt_reg;
    logic rise_irq_en_reg;
    logic fall_irq_en_reg;
    logic [2:0] inv_input_sel_reg;
    logic cmp_irq_flag_reg;
    logic cmp_irq_en_reg;
    logic cmp_prev_reg;
    logic aw_full_reg;
    logic [7:0] aw_addr_reg;
    logic w_full_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic cmp_sync;

    // the comparator output is asynchronous to aclk; nothing but the
    // first synchroniser flop may look at it
    rcc_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din(cmp_output),
        .dout(cmp_sync)
    );

    // ***********************************************************
    // write channel: address and data accepted in either order
    // ***********************************************************
    // only byte lane 0 carries register bits; other lanes are ignored
    // writes to read-only or unmapped words answer slverr, change nothing
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
    wire lane0 = w_strb_reg[0];
    wire [7:0] wbyte = w_data_reg[7:0];
    wire wr_ref = wr_fire && lane0 && (aw_addr_reg == rcc_pkg::REF_CTRL_OFS);
    wire wr_edge = wr_fire && lane0
        && (aw_addr_reg == rcc_pkg::EDGE_CTRL_OFS);
    wire wr_chan = wr_fire && lane0 && (aw_addr_reg == rcc_pkg::INV_CHAN_OFS);
    wire wr_en = wr_fire && lane0 && (aw_addr_reg == rcc_pkg::IRQ_EN_OFS);
    wire wr_clr = wr_fire && lane0 && (aw_addr_reg == rcc_pkg::IRQ_CLR_OFS)
        && wbyte[0];
    wire wr_known = (aw_addr_reg == rcc_pkg::REF_CTRL_OFS)
        || (aw_addr_reg == rcc_pkg::EDGE_CTRL_OFS)
        || (aw_addr_reg == rcc_pkg::INV_CHAN_OFS)
        || (aw_addr_reg == rcc_pkg::IRQ_EN_OFS)
        || (aw_addr_reg == rcc_pkg::IRQ_CLR_OFS);

    // holding slots drop ready so the master stalls until the response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_full_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (aw_take) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (w_take) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? 2'h0 : 2'h2; // slverr if read-only or unmapped
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ready outputs registered: high while the slot is empty
    // a slot reopens in the same cycle its response is issued
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !(aw_full_reg || aw_take) || wr_fire;
            s_axi_wready <= !(w_full_reg || w_take) || wr_fire;
        end
    end

    // ***********************************************************
    // control registers
    // ***********************************************************
    // upper bits of edge and channel registers are never stored
    // one reference write sets enable and both gain fields together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_en_reg <= 1'b0;
            adc_ref_gain_sel_reg <= 2'h0;
            dac_cmp_ref_gain_sel_reg <= 2'h0;
            rise_irq_en_reg <= 1'b0;
            fall_irq_en_reg <= 1'b0;
            inv_input_sel_reg <= 3'h0;
            cmp_irq_en_reg <= 1'b0;
        end else begin
            if (wr_ref) begin
                ref_en_reg <= wbyte[rcc_pkg::REF_EN_BIT];
                adc_ref_gain_sel_reg <= wbyte[1:0];
                dac_cmp_ref_gain_sel_reg <= wbyte[3:2];
            end
            if (wr_edge) begin
                rise_irq_en_reg <= wbyte[rcc_pkg::RISE_EN_BIT];
                fall_irq_en_reg <= wbyte[rcc_pkg::FALL_EN_BIT];
            end
            if (wr_chan) begin
                inv_input_sel_reg <= wbyte[2:0];
            end
            if (wr_en) begin
                cmp_irq_en_reg <= wbyte[0];
            end
        end
    end

    // ***********************************************************
    // settling timer and ready
    // ***********************************************************
    // the analog settle is not observable, so a fixed count stands in
    // limitation: the count assumes the clock rate in the package
    // ready restarts from zero each time the enable bit is set again
    always_ff @(posedge aclk) begin
        if (!aresetn || !ref_en_reg) begin
            settle_cnt_reg <= '0;
            ready_reg <= 1'b0;
        end else if (!ready_reg) begin
            if (settle_cnt_reg == CW'(SETTLE_CYCLES - 1)) begin
                ready_reg <= 1'b1;
            end else begin
                settle_cnt_reg <= settle_cnt_reg + 1'b1;
            end
        end
    end

    // ***********************************************************
    // comparator edge detect and sticky flag
    // ***********************************************************
    wire rise_evt = cmp_sync && !cmp_prev_reg && rise_irq_en_reg;
    wire fall_evt = !cmp_sync && cmp_prev_reg && fall_irq_en_reg;
    // prev flop resets low, the comparator's idle level: no false edge
    // an edge in the clearing cycle wins over the clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_prev_reg <= 1'b0;
            cmp_irq_flag_reg <= 1'b0;
        end else begin
            cmp_prev_reg <= cmp_sync;
            if (rise_evt || fall_evt) begin
                cmp_irq_flag_reg <= 1'b1;
            end else if (wr_clr) begin
                cmp_irq_flag_reg <= 1'b0;
            end
        end
    end

    // ***********************************************************
    // read channel
    // ***********************************************************
    wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
    // ready masked by enable: the ready flop clears one cycle late
    wire ready_rd = ready_reg && ref_en_reg;
    wire [7:0] ref_rd = {ref_en_reg, ready_rd, 2'b00,
        dac_cmp_ref_gain_sel_reg, adc_ref_gain_sel_reg};
    wire [7:0] edge_rd = {6'h00, rise_irq_en_reg, fall_irq_en_reg};
    wire [7:0] chan_rd = {5'h00, inv_input_sel_reg};
    wire [7:0] stat_rd = {7'h00, cmp_irq_flag_reg};
    wire [7:0] en_rd = {7'h00, cmp_irq_en_reg};
    wire [7:0] cmp_rd = {7'h00, cmp_sync};
    wire rd_hit_ref = rd_addr == rcc_pkg::REF_CTRL_OFS;
    wire rd_hit_edge = rd_addr == rcc_pkg::EDGE_CTRL_OFS;
    wire rd_hit_chan = rd_addr == rcc_pkg::INV_CHAN_OFS;
    wire rd_hit_stat = rd_addr == rcc_pkg::IRQ_STAT_OFS;
    wire rd_hit_en = rd_addr == rcc_pkg::IRQ_EN_OFS;
    wire rd_hit_clr = rd_addr == rcc_pkg::IRQ_CLR_OFS;
    wire rd_hit_cmp = rd_addr == rcc_pkg::CMP_STAT_OFS;
    wire rd_known = rd_hit_ref || rd_hit_edge || rd_hit_chan || rd_hit_stat
        || rd_hit_en || rd_hit_clr || rd_hit_cmp;
    wire [7:0] rd_byte = rd_hit_ref ? ref_rd
        : rd_hit_edge ? edge_rd
        : rd_hit_chan ? chan_rd
        : rd_hit_stat ? stat_rd
        : rd_hit_en ? en_rd
        : rd_hit_cmp ? cmp_rd
        : 8'h00;
    wire ar_take = s_axi_arvalid && s_axi_arready;

    // one read at a time: arready low while a response is pending
    // data is captured when the address is taken, so it stands
    // unchanged until rready whatever the flags do meanwhile
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !ar_take
                || (s_axi_rvalid && s_axi_rready);
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_known ? 2'h0 : 2'h2;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ***********************************************************
    // analog control outputs
    // ***********************************************************
    logic adc_en_w;
    logic dac_en_w;
    logic [2:0] adc_oh_w;
    logic [2:0] dac_oh_w;
    rcc_gain_dec u_adc_gain (
        .code(adc_ref_gain_sel_reg),
        .enable(adc_en_w),
        .gain_onehot(adc_oh_w)
    );
    rcc_gain_dec u_dac_gain (
        .code(dac_cmp_ref_gain_sel_reg),
        .enable(dac_en_w),
        .gain_onehot(dac_oh_w)
    );
    wire [2:0] sel = inv_input_sel_reg;
    wire [3:0] route_w = (sel[2] == 1'b0) ? (4'h1 << sel[1:0]) : 4'h0;

    // registered so each output comes straight from a flop
    // each output lags its register by one cycle
    // codes 100 and 101 leave every inverting route open
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fixed_reference_en <= 1'b0;
            adc_stage_en <= 1'b0;
            adc_gain_onehot <= 3'h0;
            dac_stage_en <= 1'b0;
            dac_gain_onehot <= 3'h0;
            inv_input_route <= 4'h0;
            inv_ref_buffer_two <= 1'b0;
            inv_ground <= 1'b0;
            irq <= 1'b0;
        end else begin
            fixed_reference_en <= ref_en_reg;
            adc_stage_en <= adc_en_w;
            adc_gain_onehot <= adc_oh_w;
            dac_stage_en <= dac_en_w;
            dac_gain_onehot <= dac_oh_w;
            inv_input_route <= route_w;
            inv_ref_buffer_two <= (sel == rcc_pkg::INV_REF_BUFFER_TWO);
            inv_ground <= (sel == rcc_pkg::INV_GROUND);
            irq <= cmp_irq_flag_reg && cmp_irq_en_reg;
        end
    end
endmodule // rcc_top

// >>> dv/rcc_afe_model.sv
// analog front end seen by the block: only the comparator decision
module rcc_afe_model (
    input wire logic sense_high, // bench command: input above threshold
    output logic cmp_output // comparator decision, async to aclk
);
    timeunit 1ns;
    timeprecision 1ps;
    // decision lags the command by an analog delay unrelated to aclk
    assign #3 cmp_output = sense_high;
endmodule // rcc_afe_model

// >>> dv/rcc_monitor.sv
module rcc_monitor #(
    parameter int SETTLE_CYCLES = 4 // settle count
) (
    input wire logic aclk, // clock
    input wire logic aresetn, // reset, active low
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic [1:0] s_axi_bresp, // b resp
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata, // r data
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic adc_stage_en, // adc stage on
    input wire logic [2:0] adc_gain_onehot, // adc gain
    input wire logic dac_stage_en, // dac stage on
    input wire logic [2:0] dac_gain_onehot, // dac gain
    input wire logic [3:0] inv_input_route, // inputs 0..3
    input wire logic inv_ref_buffer_two, // buffer two
    input wire logic inv_ground, // ground
    input wire logic irq // interrupt
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ***********************************************************
    // register bus handshakes
    // ***********************************************************
    a_wr_resp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)
    ) else $error("write response dropped before accept");
    a_rd_data_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
    ) else $error("read data dropped before accept");
    a_rd_answer_next: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    ) else $error("read answer late");
    a_rd_busy_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
    a_wr_answer_bound: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write answer missing");
    a_rd_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000
    ) else $error("upper read bits not zero");
    // ***********************************************************
    // analog controls: decodes must stay exclusive
    // ***********************************************************
    a_adc_gain_code: assert property (
        adc_stage_en ? $onehot(adc_gain_onehot) : adc_gain_onehot == 3'h0
    ) else $error("adc gain decode wrong");
    a_dac_gain_code: assert property (
        dac_stage_en ? $onehot(dac_gain_onehot) : dac_gain_onehot == 3'h0
    ) else $error("dac gain decode wrong");
    a_route_single: assert property (
        $onehot0({inv_input_route, inv_ref_buffer_two, inv_ground})
    ) else $error("two inverting routes at once");
    c_irq_up: cover property ($rose(irq));
    c_gain_x4: cover property (adc_gain_onehot[2] && dac_stage_en);
    c_ground: cover property (inv_ground);
endmodule // rcc_monitor

bind rcc_top rcc_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_monitor (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .adc_stage_en, .adc_gain_onehot, .dac_stage_en,
    .dac_gain_onehot, .inv_input_route, .inv_ref_buffer_two, .inv_ground,
    .irq
);

// >>> dv/ref_and_comparator_control_test.sv
module ref_and_comparator_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SETTLE = 40;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, sense_high, cmp_output;
    logic ref_en, adc_en, dac_en, bufb, gnd, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [2:0] adc_oh, dac_oh;
    logic [3:0] route;
    logic [3:0] wstrb;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    rcc_top #(.SETTLE_CYCLES(SETTLE)) DUT (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .cmp_output(cmp_output),
        .fixed_reference_en(ref_en), .adc_stage_en(adc_en),
        .adc_gain_onehot(adc_oh), .dac_stage_en(dac_en),
        .dac_gain_onehot(dac_oh), .inv_input_route(route),
        .inv_ref_buffer_two(bufb), .inv_ground(gnd), .irq(irq)
    );
    rcc_afe_model u_afe (.sense_high(sense_high), .cmp_output(cmp_output));
    // ***********************************************************
    // clock, watchdog and bus tasks
    // ***********************************************************
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // a hung handshake ends the run through the same report
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      input logic [1:0] er);
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!bvalid);
        // ready comes a cycle late so the hold checks see a stall
        bready <= 1'b1;
        @(posedge aclk);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ev,
                      input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b1;
        @(posedge aclk);
        rready <= 1'b0;
        chk(rdata, ev);
        chk({30'h0, rresp}, {30'h0, er});
    endtask
    // stage enable over one-hot gain for a two-bit code
    function automatic logic [3:0] gain(input int g);
        return (g == 0) ? 4'h0 : {1'b1, 3'(1 << (g - 1))};
    endfunction
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ***********************************************************
    // main sequence
    // ***********************************************************
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, sense_high} = 49'h0;
        wstrb = 4'hF;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(rcc_pkg::REF_CTRL_OFS, 32'h0, 2'h0);
        rd(rcc_pkg::EDGE_CTRL_OFS, 32'h0, 2'h0);
        rd(rcc_pkg::INV_CHAN_OFS, 32'h0, 2'h0);
        rd(8'h1C, 32'h0, 2'h2);
        wr(rcc_pkg::EDGE_CTRL_OFS, 32'hFFFFFFFF, 2'h0);
        rd(rcc_pkg::EDGE_CTRL_OFS, 32'h3, 2'h0);
        wr(rcc_pkg::INV_CHAN_OFS, 32'hFF, 2'h0);
        rd(rcc_pkg::INV_CHAN_OFS, 32'h7, 2'h0);
        // a write without byte lane 0 leaves the register as it was
        wstrb <= 4'hE;
        wr(rcc_pkg::INV_CHAN_OFS, 32'h2, 2'h0);
        wstrb <= 4'hF;
        rd(rcc_pkg::INV_CHAN_OFS, 32'h7, 2'h0);
        // every select code; bits 5:2 inputs, 1 buffer two, 0 ground
        for (int i = 0; i < 8; i++) begin
            wr(rcc_pkg::INV_CHAN_OFS, 32'(i), 2'h0);
            repeat (3) @(posedge aclk);
            chk({26'h0, route, bufb, gnd}, (i < 4) ? 32'(4 << i) :
                (i == 6) ? 32'h2 : (i == 7) ? 32'h1 : 32'h0);
        end
        // both gain fields set at once to opposite codes
        for (int g = 0; g < 4; g++) begin
            wr(rcc_pkg::REF_CTRL_OFS, 32'(((3 - g) << 2) | g), 2'h0);
            repeat (3) @(posedge aclk);
            chk({28'h0, adc_en, adc_oh}, {28'h0, gain(g)});
            chk({28'h0, dac_en, dac_oh}, {28'h0, gain(3 - g)});
            rd(rcc_pkg::REF_CTRL_OFS, 32'(((3 - g) << 2) | g), 2'h0);
        end
        wr(rcc_pkg::REF_CTRL_OFS, 32'h80, 2'h0);
        repeat (3) @(posedge aclk);
        chk({31'h0, ref_en}, 32'h1);
        rd(rcc_pkg::REF_CTRL_OFS, 32'h80, 2'h0);
        repeat (SETTLE + 5) @(posedge aclk);
        rd(rcc_pkg::REF_CTRL_OFS, 32'hC0, 2'h0);
        wr(rcc_pkg::REF_CTRL_OFS, 32'h0, 2'h0);
        rd(rcc_pkg::REF_CTRL_OFS, 32'h0, 2'h0);
        chk({31'h0, ref_en}, 32'h0);
        // every edge mode, irq enable toggled with bit 0 of the mode
        for (int m = 0; m < 4; m++) begin
            wr(rcc_pkg::EDGE_CTRL_OFS, 32'(m), 2'h0);
            wr(rcc_pkg::IRQ_EN_OFS, 32'(m & 1), 2'h0);
            sense_high <= 1'b1;
            repeat (8) @(posedge aclk);
            rd(rcc_pkg::IRQ_STAT_OFS, 32'((m >> 1) & 1), 2'h0);
            chk({31'h0, irq}, 32'(m & (m >> 1) & 1));
            rd(rcc_pkg::CMP_STAT_OFS, 32'h1, 2'h0);
            wr(rcc_pkg::IRQ_CLR_OFS, 32'h1, 2'h0);
            rd(rcc_pkg::IRQ_STAT_OFS, 32'h0, 2'h0);
            sense_high <= 1'b0;
            repeat (8) @(posedge aclk);
            rd(rcc_pkg::IRQ_STAT_OFS, 32'(m & 1), 2'h0);
            chk({31'h0, irq}, 32'(m & 1));
            wr(rcc_pkg::IRQ_CLR_OFS, 32'h1, 2'h0);
        end
        test_done();
    end
endmodule // ref_and_comparator_control_test
